// ---- design/fnd_dsm.sv ----
// Delta-sigma modulator: one divide ratio per detector comparison.
// Assumes pd_tick is a one-cycle pulse from the reference divider.
`timescale 1ns/1ps
module fnd_dsm
   import fnd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   fnd_dsm_if.dsm dif
);
   logic [FRAC_W-1:0] acc, next_acc;
   logic [STEP_W-1:0] cnt, next_cnt;
   logic [NDIV_W-1:0] next_n_div;
   logic next_n_valid;
   logic [FRAC_W:0] sum;

   // Accumulate the fraction; the carry adds one to the integer ratio
   always_comb begin
      sum = {1'b0, acc} + {1'b0, dif.frac_word};
      next_acc = acc;
      next_cnt = cnt;
      next_n_div = dif.n_div;
      next_n_valid = 1'b0;
      if (dif.pd_tick) begin
         next_n_valid = 1'b1;
         if (!dif.frac_en) begin
            next_n_div = {1'b0, dif.int_word};
            next_cnt = '0;
         end else begin
            // average ratio int plus frac over 2^24 while exact mode is off
            next_n_div = {1'b0, dif.int_word} + {{INT_W{1'b0}}, sum[FRAC_W]};
            next_acc = sum[FRAC_W-1:0];
            // full modulus, residue cleared each step cycle
            if (dif.exact_en) begin
               if (cnt >= dif.step_count - 1'b1) begin
                  next_cnt = '0;
                  next_acc = '0;
               end else begin
                  next_cnt = cnt + 1'b1;
               end
            end else begin
               next_cnt = '0;
            end
         end
      end
   end

   // Registers only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc <= '0;
         cnt <= '0;
         dif.n_div <= '0;
         dif.n_valid <= 1'b0;
      end else if (ce) begin
         acc <= next_acc;
         cnt <= next_cnt;
         dif.n_div <= next_n_div;
         dif.n_valid <= next_n_valid;
      end
   end

   // Integer mode passes the integer word unchanged
   a_int_mode_ratio: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && dif.pd_tick && !dif.frac_en |=>
      dif.n_valid && dif.n_div == {1'b0, $past(dif.int_word)})
      else $error("integer mode ratio differs from integer word");
   // Fractional ratio is integer or integer plus one
   a_frac_carry: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && dif.pd_tick && dif.frac_en |=>
      dif.n_div - {1'b0, $past(dif.int_word)} <= 20'h00001)
      else $error("fractional ratio outside int to int plus one");
   // Step counter stays below the programmed step count; a frozen
   // cycle leaves the counter untouched, so only enabled steps count
   a_exact_cnt: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      dif.exact_en && dif.frac_en && $stable(dif.step_count) &&
      dif.step_count != '0 && $past(dif.pd_tick) && $past(ce) |->
      cnt < dif.step_count)
      else $error("exact step counter passed step count");
   // Accumulator cleared at end of each exact cycle
   a_exact_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && dif.pd_tick && dif.frac_en && dif.exact_en &&
      cnt >= dif.step_count - 1'b1 |=> acc == '0)
      else $error("exact cycle did not clear accumulator");
   c_exact_wrap: cover property (@(posedge clk_sys)
      ce && dif.pd_tick && dif.exact_en && cnt != '0);
   c_carry: cover property (@(posedge clk_sys)
      ce && dif.pd_tick && dif.frac_en && sum[FRAC_W]);
endmodule : fnd_dsm

// ---- design/fnd_dsm_if.sv ----
// Carries the modulator setup and the per-comparison divide ratio.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface fnd_dsm_if;
   import fnd_pkg::*;
   logic pd_tick;
   logic frac_en;
   logic exact_en;
   logic [INT_W-1:0] int_word;
   logic [FRAC_W-1:0] frac_word;
   logic [STEP_W-1:0] step_count;
   logic [NDIV_W-1:0] n_div;
   logic n_valid;
   modport ctl (output pd_tick, frac_en, exact_en, int_word, frac_word,
      step_count, input n_div, n_valid);
   modport dsm (input pd_tick, frac_en, exact_en, int_word, frac_word,
      step_count, output n_div, n_valid);
endinterface : fnd_dsm_if

// ---- design/fnd_pkg.sv ----
// Constants for the fractional-N divider control block.
// Assumes a single clk_sys domain and that the host serial port has already
// been decoded into register read and write strobes.
// What this block does
// - Integer mode turns modulator off; integer word 16 to 2^19-1 is used.
// - VCO frequency equals reference over R times integer plus frac/2^24.
// - Integer word is 19 bits, fractional word 24 bits, separate registers.
// - Output is VCO divided by k: 0.5, 1, or even 2 to 62.
// - Oscillator subsystem writes pass only through forwarding register 5.
// - Reference is divided by R; detector runs at reference over R.
// - Exact mode takes step count from the step register, below 2^14.
// - Exact mode keeps the full 24-bit accumulator modulus.
package fnd_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 24;
   localparam int INT_W = 19;
   localparam int FRAC_W = 24;
   localparam int STEP_W = 14;
   localparam int NDIV_W = 20;
   localparam int ODIV_W = 6;
   // Register offsets
   localparam logic [3:0] A_REF = 4'h2;
   localparam logic [3:0] A_INT = 4'h3;
   localparam logic [3:0] A_FRAC = 4'h4;
   localparam logic [3:0] A_FWD = 4'h5;
   localparam logic [3:0] A_MODE = 4'h6;
   localparam logic [3:0] A_EXACT = 4'hc;
   // Mode control fields
   localparam int MODE_FRAC_EN_BIT = 11;
   localparam int MODE_BYPASS_BIT = 7;
   // Forwarding word layout: subsystem register address, then its data
   localparam int FWD_ADDR_LSB = 0;
   localparam int FWD_DATA_LSB = 4;
   localparam logic [3:0] VCO_REG_DIV = 4'h2;
   localparam logic [3:0] VCO_REG_DBL = 4'h3;
   localparam logic [5:0] ODIV_MAX = 6'h3e;
   // Divide ratio limits
   localparam logic [18:0] N_MIN_INT = 19'h00010;
   localparam logic [18:0] N_MIN_FRAC = 19'h00014;
   localparam logic [18:0] N_MAX_FRAC = 19'h7fffc;
   // Reset values
   localparam logic [23:0] REF_RST = 24'h000001;
   localparam logic [18:0] INT_RST = 19'h00010;
   localparam logic [23:0] FRAC_RST = 24'h000000;
   localparam logic [23:0] FWD_RST = 24'h000000;
   localparam logic [23:0] MODE_RST = 24'h000080;
   localparam logic [23:0] EXACT_RST = 24'h000000;
   localparam logic [5:0] ODIV_RST = 6'h01;
endpackage : fnd_pkg

// ---- design/fnd_top.sv ----
// Divider and modulator control registers of the synthesizer core.
// Assumes decoded serial-port strobes and a one-cycle reference edge pulse,
// all synchronous to clk_sys.
`timescale 1ns/1ps
module fnd_top
   import fnd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic ref_tick,
   output logic [DATA_W-1:0] reg_rdata,
   output logic pd_tick,
   output logic [NDIV_W-1:0] n_div,
   output logic n_valid,
   output logic [DATA_W-1:0] vco_wr_data,
   output logic vco_wr_stb,
   output logic [ODIV_W-1:0] out_div,
   output logic doubler_en,
   output logic frac_active,
   output logic exact_active,
   output logic ratio_bad
);
   logic [DATA_W-1:0] ref_div, next_ref_div;
   logic [INT_W-1:0] int_word, next_int_word;
   logic [FRAC_W-1:0] frac_word, next_frac_word;
   logic [DATA_W-1:0] fwd_word, next_fwd_word;
   logic [DATA_W-1:0] mode_word, next_mode_word;
   logic [DATA_W-1:0] exact_word, next_exact_word;
   logic [DATA_W-1:0] next_reg_rdata;
   logic [DATA_W-1:0] next_vco_wr_data;
   logic next_vco_wr_stb;
   logic [ODIV_W-1:0] next_out_div;
   logic next_doubler_en;
   logic next_frac_active, next_exact_active, next_ratio_bad;
   logic [DATA_W-1:0] ref_cnt, next_ref_cnt;
   logic next_pd_tick;
   logic [DATA_W-1:0] ref_last;
   logic [3:0] fwd_addr;
   logic [ODIV_W-1:0] fwd_div;
   logic fwd_div_ok;
   logic wr_ref;

   fnd_dsm_if dif ();

   // Register writes and reads; unmapped reads return zero
   always_comb begin
      next_ref_div = ref_div;
      next_int_word = int_word;
      next_frac_word = frac_word;
      next_fwd_word = fwd_word;
      next_mode_word = mode_word;
      next_exact_word = exact_word;
      next_reg_rdata = reg_rdata;
      wr_ref = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            A_REF: begin
               next_ref_div = reg_wdata;
               wr_ref = 1'b1;
            end
            A_INT: next_int_word = reg_wdata[INT_W-1:0];
            A_FRAC: next_frac_word = reg_wdata[FRAC_W-1:0];
            A_FWD: next_fwd_word = reg_wdata;
            A_MODE: next_mode_word = reg_wdata;
            A_EXACT: next_exact_word = reg_wdata;
            default: next_ref_div = ref_div;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            A_REF: next_reg_rdata = ref_div;
            A_INT: next_reg_rdata = {{(DATA_W-INT_W){1'b0}}, int_word};
            A_FRAC: next_reg_rdata = frac_word;
            A_FWD: next_reg_rdata = fwd_word;
            A_MODE: next_reg_rdata = mode_word;
            A_EXACT: next_reg_rdata = exact_word;
            default: next_reg_rdata = '0;
         endcase
      end
   end

   // Forwarded writes to the oscillator subsystem; its shadowed selectors
   // accept only legal codes so a bad write cannot leave k undefined
   always_comb begin
      fwd_addr = reg_wdata[FWD_ADDR_LSB +: 4];
      fwd_div = reg_wdata[FWD_DATA_LSB +: ODIV_W];
      fwd_div_ok = (fwd_div == ODIV_RST) ||
         (!fwd_div[0] && fwd_div != '0 && fwd_div <= ODIV_MAX);
      next_vco_wr_data = vco_wr_data;
      next_vco_wr_stb = 1'b0;
      next_out_div = out_div;
      next_doubler_en = doubler_en;
      if (reg_wr && reg_addr == A_FWD) begin
         next_vco_wr_data = reg_wdata;
         next_vco_wr_stb = 1'b1;
         // k of 1, even 2 to 62, or doubler
         if (fwd_addr == VCO_REG_DIV && fwd_div_ok) begin
            next_out_div = fwd_div;
         end
         if (fwd_addr == VCO_REG_DBL) begin
            next_doubler_en = reg_wdata[FWD_DATA_LSB];
         end
      end
   end

   // Reference divider; an R of zero behaves as one
   always_comb begin
      ref_last = (ref_div == '0) ? '0 : ref_div - 1'b1;
      next_ref_cnt = ref_cnt;
      next_pd_tick = 1'b0;
      // one detector tick per R reference edges
      if (wr_ref) begin
         next_ref_cnt = '0;
      end else if (ref_tick) begin
         if (ref_cnt >= ref_last) begin
            next_ref_cnt = '0;
            next_pd_tick = 1'b1;
         end else begin
            next_ref_cnt = ref_cnt + 1'b1;
         end
      end
   end

   // Mode decode; bypass set wins so an odd combination stays integer
   always_comb begin
      // integer mode when enable clear or bypass set
      next_frac_active = mode_word[MODE_FRAC_EN_BIT] &&
         !mode_word[MODE_BYPASS_BIT];
      // nonzero step count selects exact mode
      next_exact_active = next_frac_active &&
         exact_word[STEP_W-1:0] != '0;
      if (next_frac_active) begin
         next_ratio_bad = int_word < N_MIN_FRAC || int_word > N_MAX_FRAC;
      end else begin
         next_ratio_bad = int_word < N_MIN_INT;
      end
   end

   assign dif.pd_tick = pd_tick;
   assign dif.frac_en = frac_active;
   assign dif.exact_en = exact_active;
   assign dif.int_word = int_word;
   assign dif.frac_word = frac_word;
   assign dif.step_count = exact_word[STEP_W-1:0];
   assign n_div = dif.n_div;
   assign n_valid = dif.n_valid;

   fnd_dsm u_dsm (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .dif(dif)
   );

   // Registers only; ce low freezes everything
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ref_div <= REF_RST;
         int_word <= INT_RST;
         frac_word <= FRAC_RST;
         fwd_word <= FWD_RST;
         mode_word <= MODE_RST;
         exact_word <= EXACT_RST;
         reg_rdata <= '0;
         vco_wr_data <= '0;
         vco_wr_stb <= 1'b0;
         out_div <= ODIV_RST;
         doubler_en <= 1'b0;
         ref_cnt <= '0;
         pd_tick <= 1'b0;
         frac_active <= 1'b0;
         exact_active <= 1'b0;
         ratio_bad <= 1'b0;
      end else if (ce) begin
         ref_div <= next_ref_div;
         int_word <= next_int_word;
         frac_word <= next_frac_word;
         fwd_word <= next_fwd_word;
         mode_word <= next_mode_word;
         exact_word <= next_exact_word;
         reg_rdata <= next_reg_rdata;
         vco_wr_data <= next_vco_wr_data;
         vco_wr_stb <= next_vco_wr_stb;
         out_div <= next_out_div;
         doubler_en <= next_doubler_en;
         ref_cnt <= next_ref_cnt;
         pd_tick <= next_pd_tick;
         frac_active <= next_frac_active;
         exact_active <= next_exact_active;
         ratio_bad <= next_ratio_bad;
      end
   end

   // Forwarded write appears on the subsystem strobe next cycle
   a_fwd_strobe: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && reg_wr && reg_addr == A_FWD |=>
      vco_wr_stb && vco_wr_data == $past(reg_wdata))
      else $error("forwarded write not passed on");
   // No fresh subsystem strobe without a forwarding write; a strobe
   // frozen by ce low is the old one still standing
   a_fwd_only: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      vco_wr_stb && $past(ce) |-> $past(reg_wr && reg_addr == A_FWD))
      else $error("subsystem strobe without forwarding write");
   // Divider count stays below R
   a_ref_range: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ref_div != '0 && $stable(ref_div) |-> ref_cnt < ref_div)
      else $error("reference count reached R");
   // Output divider only ever holds a legal code
   a_odiv_legal: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      out_div == ODIV_RST || (!out_div[0] && out_div != '0 &&
      out_div <= ODIV_MAX))
      else $error("illegal output divider code");
   c_fwd_write: cover property (@(posedge clk_sys) vco_wr_stb);
   c_pd_tick: cover property (@(posedge clk_sys) pd_tick && frac_active);
endmodule : fnd_top

// ---- dv/fnd_host.sv ----
// Host controller model that programs the divider registers.
// Assumes the bench calls its tasks; requests launch on falling edges.
`timescale 1ns/1ps
module fnd_host
   import fnd_pkg::*;
(
   input wire logic clk_sys,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 24'h000000;
   end
   // Released fields are inverted so a stale word never looks valid
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // Read data is taken two edges after the strobe, where it has settled
   task automatic rd(input logic [3:0] a, output logic [23:0] d);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask : rd
   task automatic int_mode();
      wr(A_MODE, 24'h000080);
   endtask : int_mode
   task automatic frac_mode();
      wr(A_MODE, 24'h000800);
   endtask : frac_mode
   task automatic fwd(input logic [3:0] a, input logic [8:0] d);
      wr(A_FWD, {11'h000, d, a});
   endtask : fwd
   task automatic exact_setup(input logic [23:0] n, input logic [23:0] s,
      input logic [23:0] f);
      wr(A_INT, n);
      wr(A_EXACT, s);
      wr(A_FRAC, f);
   endtask : exact_setup
endmodule : fnd_host

// ---- dv/test_fractional_n_divider_tuning.sv ----
// Self-checking bench for the divider control block with a host model.
// Assumes fnd_host drives the register strobes; bench drives ref_tick, ce.
`timescale 1ns/1ps
module test_fractional_n_divider_tuning
   import fnd_pkg::*;
;
   typedef struct {logic [3:0] a; logic [23:0] d; logic [23:0] q;
      logic bad; logic fr;} fnd_row_s;
   logic clk_sys, rst_n, ce, ref_tick, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, vco_wr_data;
   logic pd_tick, n_valid, vco_wr_stb, doubler_en;
   logic frac_active, exact_active, ratio_bad;
   logic [NDIV_W-1:0] n_div;
   logic [ODIV_W-1:0] out_div;
   logic [23:0] v, s0, c0, n_sum, nv_cnt, pd_cnt, stb_cnt;
   int err_total, samples_checked;
   fnd_row_s rows [14];
   logic [3:0] fa [8] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3};
   logic [8:0] fd [8] = '{9'h004, 9'h005, 9'h03f, 9'h000, 9'h03e, 9'h001,
      9'h001, 9'h000};
   logic [6:0] fe [8] = '{7'h04, 7'h04, 7'h04, 7'h04, 7'h3e, 7'h01,
      7'h41, 7'h01};
   fnd_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .ref_tick(ref_tick), .reg_rdata(reg_rdata), .pd_tick(pd_tick),
      .n_div(n_div), .n_valid(n_valid), .vco_wr_data(vco_wr_data),
      .vco_wr_stb(vco_wr_stb), .out_div(out_div), .doubler_en(doubler_en),
      .frac_active(frac_active), .exact_active(exact_active),
      .ratio_bad(ratio_bad));
   fnd_host u_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Pulse counters; n_div sums catch modulator carries
   always @(posedge clk_sys) begin
      if (n_valid === 1'b1) begin
         nv_cnt = nv_cnt + 24'h000001;
         n_sum = n_sum + {4'h0, n_div};
      end
      if (pd_tick === 1'b1) pd_cnt = pd_cnt + 24'h000001;
      if (vco_wr_stb === 1'b1) stb_cnt = stb_cnt + 24'h000001;
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   // Reference edges two cycles apart, then the fixed answer latency
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         ref_tick = 1'b1;
         @(negedge clk_sys);
         ref_tick = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
   endtask : ticks
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      ref_tick = 1'b0;
      {n_sum, nv_cnt, pd_cnt, stb_cnt} = '0;
      err_total = 0;
      samples_checked = 0;
      rows[0] = '{A_MODE, 24'h000080, 24'h000080, 1'b0, 1'b0};
      rows[1] = '{A_INT, 24'hffffff, 24'h07ffff, 1'b0, 1'b0};
      rows[2] = '{A_INT, 24'h00000f, 24'h00000f, 1'b1, 1'b0};
      rows[3] = '{A_INT, 24'h000010, 24'h000010, 1'b0, 1'b0};
      rows[4] = '{A_MODE, 24'h000800, 24'h000800, 1'b1, 1'b1};
      rows[5] = '{A_INT, 24'h000014, 24'h000014, 1'b0, 1'b1};
      rows[6] = '{A_INT, 24'h000013, 24'h000013, 1'b1, 1'b1};
      rows[7] = '{A_INT, 24'h07fffc, 24'h07fffc, 1'b0, 1'b1};
      rows[8] = '{A_INT, 24'h07fffd, 24'h07fffd, 1'b1, 1'b1};
      rows[9] = '{A_MODE, 24'h000880, 24'h000880, 1'b0, 1'b0};
      rows[10] = '{A_FRAC, 24'habcdef, 24'habcdef, 1'b0, 1'b0};
      rows[11] = '{A_REF, 24'h000003, 24'h000003, 1'b0, 1'b0};
      rows[12] = '{A_EXACT, 24'h000002, 24'h000002, 1'b0, 1'b0};
      rows[13] = '{4'h7, 24'h5a5a5a, 24'h000000, 1'b0, 1'b0};
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      u_host.rd(A_REF, v);
      chk(v, 24'h000001);
      chk({18'h00000, out_div}, 24'h000001);
      // Register rows: write, read back, then mode status
      for (int i = 0; i < 14; i++) begin
         u_host.wr(rows[i].a, rows[i].d);
         u_host.rd(rows[i].a, v);
         chk(v, rows[i].q);
         // Exact mode never shows while the rows stay out of it
         v = {21'h0, 1'b0, rows[i].bad, rows[i].fr};
         chk({21'h0, exact_active, ratio_bad, frac_active}, v);
      end
      // Integer mode uses the integer word unchanged
      u_host.int_mode();
      u_host.wr(A_INT, 24'h000064);
      u_host.wr(A_REF, 24'h000001);
      s0 = n_sum;
      c0 = nv_cnt;
      ticks(3);
      chk(nv_cnt - c0, 24'h000003);
      chk(n_sum - s0, 24'h00012c);
      // Reference divided by three
      u_host.wr(A_REF, 24'h000003);
      c0 = pd_cnt;
      ticks(6);
      chk(pd_cnt - c0, 24'h000002);
      // An R of zero is taken as one
      u_host.wr(A_REF, 24'h000000);
      c0 = pd_cnt;
      ticks(2);
      chk(pd_cnt - c0, 24'h000002);
      // Half fraction carries on every second comparison
      u_host.wr(A_REF, 24'h000001);
      u_host.frac_mode();
      u_host.wr(A_INT, 24'h000038);
      u_host.wr(A_FRAC, 24'h800000);
      s0 = n_sum;
      ticks(4);
      chk({23'h0, frac_active}, 24'h000001);
      chk(n_sum - s0, 24'h0000e2);
      // Two-step exact plan clears the accumulator before any carry
      u_host.exact_setup(24'h000038, 24'h000002, 24'h600000);
      chk({23'h0, exact_active}, 24'h000001);
      ticks(4);
      s0 = n_sum;
      ticks(8);
      chk(n_sum - s0, 24'h0001c0);
      // Clock enable low ignores a write
      @(negedge clk_sys);
      ce = 1'b0;
      u_host.wr(A_FRAC, 24'h111111);
      ce = 1'b1;
      u_host.rd(A_FRAC, v);
      chk(v, 24'h600000);
      // Forwarded words; illegal divider codes leave out_div alone
      for (int i = 0; i < 8; i++) begin
         c0 = stb_cnt;
         u_host.fwd(fa[i], fd[i]);
         repeat (2) @(negedge clk_sys);
         chk(stb_cnt - c0, 24'h000001);
         chk(vco_wr_data, {11'h000, fd[i], fa[i]});
         chk({17'h0, doubler_en, out_div}, {17'h0, fe[i]});
      end
      // Reset in mid-run restores defaults
      @(negedge clk_sys);
      rst_n = 1'b0;
      @(negedge clk_sys);
      chk({17'h0, doubler_en, out_div}, 24'h000001);
      rst_n = 1'b1;
      u_host.rd(A_MODE, v);
      chk(v, 24'h000080);
      end_sim();
   end
endmodule : test_fractional_n_divider_tuning
